/* File: rtl/ubd_pkg.sv */
// ============================================================================
// Shared constants and carriers of the bus driver.
package ubd_pkg;

  // ==========================================================================
  // Widths and synchroniser depth.
  localparam int UBD_WIDTH       = 16;
  localparam int UBD_SYNC_STAGES = 2;

  // ==========================================================================
  // Reset values.
  localparam logic [UBD_WIDTH-1:0] UBD_DATA_RESET = 16'h0000;
  localparam logic                 UBD_OE_RESET   = 1'h0;
  localparam logic                 UBD_CLK_RESET  = 1'h0;
  localparam logic                 UBD_CTL_RESET  = 1'h1;

  // ==========================================================================
  // Packed pin image as it leaves the synchroniser.
  // Field order is fixed: data in the low bits, then the three controls.
  localparam int UBD_PIN_BITS = UBD_WIDTH + 3;

  typedef struct packed {
    logic                 bus_clock;
    logic                 transparency_select_n;
    logic                 oe_n;
    logic [UBD_WIDTH-1:0] data;
  } ubd_pin_in_type;

  typedef struct packed {
    logic                 oe;
    logic [UBD_WIDTH-1:0] data;
  } ubd_pin_out_type;

  // ==========================================================================
  // Operating modes of the storage stage.
  typedef enum logic [1:0] {
    UBD_MODE_TRANSPARENT,
    UBD_MODE_HOLD,
    UBD_MODE_CAPTURE
  } ubd_mode_type;

  localparam ubd_pin_in_type UBD_PIN_RESET = '{
    bus_clock:             UBD_CLK_RESET,
    transparency_select_n: UBD_CTL_RESET,
    oe_n:                  UBD_CTL_RESET,
    data:                  UBD_DATA_RESET
  };

endpackage

/* File: rtl/ubd_sync.sv */
`timescale 1ns/100ps
// ============================================================================
// Multi-stage synchroniser for the pin inputs.
module ubd_sync #(
  parameter int WIDTH  = ubd_pkg::UBD_PIN_BITS,
  parameter int STAGES = ubd_pkg::UBD_SYNC_STAGES
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Reset image and asynchronous input.
  input  wire logic [WIDTH-1:0] reset_value,
  input  wire logic [WIDTH-1:0] async_in,
  // Synchronised output.
  output logic      [WIDTH-1:0] sync_out
);
  import ubd_pkg::*;

  logic [WIDTH-1:0] chain      [STAGES];
  logic [WIDTH-1:0] next_chain [STAGES];

  // ==========================================================================
  // Shift chain; only the last stage leaves the module.
  always_comb begin
    next_chain[0] = async_in;
    for (int i = 1; i < STAGES; i++) begin
      next_chain[i] = chain[i-1];
    end
  end

  // The reset image is a tied constant at the instance.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < STAGES; i++) begin
        chain[i] <= WIDTH'(UBD_PIN_RESET);
      end
    end else begin
      for (int i = 0; i < STAGES; i++) begin
        chain[i] <= next_chain[i];
      end
    end
  end

  always_comb begin
    sync_out = chain[STAGES-1];
  end

  // The reset image port is kept for instance documentation only.
  logic unused_reset_value;
  always_comb begin
    unused_reset_value = ^reset_value;
  end

endmodule

/* File: rtl/ubd_driver.sv */
`timescale 1ns/100ps
// ============================================================================
// Sixteen-bit universal bus driver: transparent latch, hold, or clocked
// capture, with an active-low output enable on the whole output word.
module ubd_driver #(
  parameter int WIDTH = ubd_pkg::UBD_WIDTH
) (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // Input pins.
  input  wire logic [WIDTH-1:0]   data_in,
  input  wire logic               oe_n,
  input  wire logic               transparency_select_n,
  input  wire logic               bus_clock,
  // Output pins, as data and enable.
  output logic      [WIDTH-1:0]   y_out,
  output logic      [WIDTH-1:0]   y_oe,
  // Current operating mode of the storage stage.
  output ubd_pkg::ubd_mode_type   mode
);
  import ubd_pkg::*;

  // ==========================================================================
  // Pin synchronisation.
  // Each bit is synchronised on its own, so a word must settle a cycle early.
  ubd_pin_in_type pin_raw;
  ubd_pin_in_type pin;
  logic [UBD_PIN_BITS-1:0] pin_sync;

  always_comb begin
    pin_raw                       = UBD_PIN_RESET;
    pin_raw.data                  = data_in[UBD_WIDTH-1:0];
    pin_raw.oe_n                  = oe_n;
    pin_raw.transparency_select_n = transparency_select_n;
    pin_raw.bus_clock             = bus_clock;
  end

  ubd_sync #(
    .WIDTH  (UBD_PIN_BITS),
    .STAGES (UBD_SYNC_STAGES)
  ) u_sync (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .reset_value (UBD_PIN_RESET),
    .async_in    (pin_raw),
    .sync_out    (pin_sync)
  );

  always_comb begin
    pin = ubd_pin_in_type'(pin_sync);
  end

  // ==========================================================================
  // Clock edge detection on the synchronised bus clock.
  logic bus_clock_prev;
  logic next_bus_clock_prev;
  logic bus_clock_rise;

  always_comb begin
    next_bus_clock_prev = pin.bus_clock;
    bus_clock_rise      = pin.bus_clock & ~bus_clock_prev;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_clock_prev <= UBD_CLK_RESET;
    end else begin
      bus_clock_prev <= next_bus_clock_prev;
    end
  end

  // ==========================================================================
  // Mode selection from the select input and the clock edge.
  ubd_mode_type next_mode;

  always_comb begin
    if (!pin.transparency_select_n) begin
      next_mode = UBD_MODE_TRANSPARENT;
    end else if (bus_clock_rise) begin
      next_mode = UBD_MODE_CAPTURE;
    end else begin
      next_mode = UBD_MODE_HOLD;
    end
  end

  // ==========================================================================
  // Storage stage; the stored word is the output register itself.
  ubd_pin_out_type out_reg;
  ubd_pin_out_type next_out_reg;

  always_comb begin
    next_out_reg = out_reg;
    // The enable does not enter the storage decision.
    case (next_mode)
      UBD_MODE_TRANSPARENT: begin
        next_out_reg.data = pin.data;
      end
      UBD_MODE_CAPTURE: begin
        next_out_reg.data = pin.data;
      end
      UBD_MODE_HOLD: begin
        next_out_reg.data = out_reg.data;
      end
      default: begin
        next_out_reg.data = out_reg.data;
      end
    endcase
    // Drive depends on the enable pin alone.
    next_out_reg.oe = ~pin.oe_n;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_reg.data <= UBD_DATA_RESET;
      out_reg.oe   <= UBD_OE_RESET;
      mode         <= UBD_MODE_HOLD;
    end else begin
      out_reg <= next_out_reg;
      mode    <= next_mode;
    end
  end

  // ==========================================================================
  // Output pins.
  always_comb begin
    y_out = out_reg.data;
    y_oe  = {WIDTH{out_reg.oe}};
  end

endmodule

/* File: tb/ubd_driver_sva.sv */
`timescale 1ns/100ps
// ====================
// Port checks of the bus driver.
module ubd_driver_sva #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] data_in,
  input  wire logic             oe_n,
  input  wire logic             transparency_select_n,
  input  wire logic             bus_clock,
  input  wire logic [WIDTH-1:0] y_out,
  input  wire logic [WIDTH-1:0] y_oe,
  input  ubd_pkg::ubd_mode_type mode
);
  import ubd_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  oe_track_a: assert property (y_oe == {WIDTH{~$past(oe_n, 3)}})
    else $error("output enable mismatch");
  oe_only_a: assert property ($stable(y_oe) || $past(oe_n, 3) != $past(oe_n, 4))
    else $error("output enable moved without cause");
  pass_data_a: assert property (!$past(transparency_select_n, 3) |-> y_out == $past(data_in, 3))
    else $error("transparent data mismatch");
  pass_mode_a: assert property (!$past(transparency_select_n, 3) |-> mode == UBD_MODE_TRANSPARENT)
    else $error("transparent mode mismatch");
  off_pass_a: assert property ($past(oe_n, 3) && !$past(transparency_select_n, 3)
    |-> y_out == $past(data_in, 3))
    else $error("stored data stalled while disabled");
  cap_data_a: assert property ($past(transparency_select_n, 3) && $past(bus_clock, 3)
    && !$past(bus_clock, 4) |-> y_out == $past(data_in, 3))
    else $error("captured data mismatch");
  cap_mode_a: assert property ($past(transparency_select_n, 3) && $past(bus_clock, 3)
    && !$past(bus_clock, 4) |-> mode == UBD_MODE_CAPTURE)
    else $error("capture mode mismatch");
  hold_data_a: assert property ($past(transparency_select_n, 3)
    && !($past(bus_clock, 3) && !$past(bus_clock, 4)) |-> $stable(y_out))
    else $error("held data changed");
  hold_mode_a: assert property ($past(transparency_select_n, 3)
    && !($past(bus_clock, 3) && !$past(bus_clock, 4)) |-> mode == UBD_MODE_HOLD)
    else $error("hold mode mismatch");
endmodule

bind ubd_driver ubd_driver_sva #(.WIDTH(WIDTH)) chk (.*);

/* File: tb/ubd_bus_load.sv */
`timescale 1ns/100ps
// ====================
// Module-side load that resolves the three-state word.
module ubd_bus_load (
  input  wire logic [15:0] y_out,
  input  wire logic [15:0] y_oe,
  output wire logic [15:0] y
);
  for (genvar i = 0; i < 16; i++) begin : g_bit
    assign y[i] = y_oe[i] ? y_out[i] : 1'hz;
  end
endmodule

/* File: tb/tb_ubd_driver.sv */
`timescale 1ns/100ps
// ====================
// Directed bench of the bus driver.
module tb_ubd_driver;
  import ubd_pkg::*;
  logic         clk = 1'h0;
  logic         sys_rst = 1'h1;
  logic         oe_n = 1'h1;
  logic         sel_n = 1'h1;
  logic         bus_clock = 1'h0;
  logic [15:0]  data_in = 16'h0000;
  logic [15:0]  y_out;
  logic [15:0]  y_oe;
  wire  [15:0]  y;
  ubd_mode_type mode;
  int           fail_count = 0;
  int           num_checks = 0;
  ubd_driver dut (.clk(clk), .sys_rst(sys_rst), .data_in(data_in), .oe_n(oe_n),
    .transparency_select_n(sel_n), .bus_clock(bus_clock), .y_out(y_out), .y_oe(y_oe),
    .mode(mode));
  ubd_bus_load load (.y_out(y_out), .y_oe(y_oe), .y(y));
  initial forever #5 clk = ~clk;
  task step(input logic [15:0] d, input logic o, input logic s, input logic c);
    @(negedge clk);
    data_in = d;
    oe_n = o;
    sel_n = s;
    bus_clock = c;
    repeat (4) @(negedge clk);
  endtask
  task chk(input logic [15:0] e);
    num_checks++;
    if (y !== e) begin
      fail_count++;
      $display("Error y expected %h seen %h", e, y);
    end
  endtask
  task close_out;
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task t_off;
    step(16'ha5a5, 1'h1, 1'h0, 1'h0);
    chk('z);
    step(16'h5a5a, 1'h1, 1'h1, 1'h1);
    chk('z);
    step(16'h0f0f, 1'h0, 1'h1, 1'h1);
    chk(16'h5a5a);
  endtask
  task t_pass;
    step(16'h1234, 1'h0, 1'h0, 1'h0);
    chk(16'h1234);
    step(16'h8001, 1'h0, 1'h0, 1'h1);
    chk(16'h8001);
  endtask
  task t_hold;
    step(16'hffff, 1'h0, 1'h1, 1'h1);
    chk(16'h8001);
    step(16'hc3c3, 1'h0, 1'h1, 1'h0);
    chk(16'h8001);
  endtask
  task t_cap;
    step(16'hc3c3, 1'h0, 1'h1, 1'h1);
    chk(16'hc3c3);
    step(16'h3c3c, 1'h0, 1'h1, 1'h1);
    chk(16'hc3c3);
    step(16'h3c3c, 1'h0, 1'h1, 1'h0);
    step(16'h3c3c, 1'h0, 1'h1, 1'h1);
    chk(16'h3c3c);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    sys_rst = 1'h0;
    t_off;
    t_pass;
    t_hold;
    t_cap;
    close_out;
  end
  initial begin
    #5000;
    fail_count++;
    close_out;
  end
endmodule
